/* logic/frx_pkg.sv */
// constants and types shared by the fault recovery and indicator logic
// What this block does
// RULE_01: enable low longer than 1 ms enters sleep, overriding all but undervoltage.
// RULE_02: host recovery pulse on enable lasts 10 to 200 us, typically 20 us; code accepts any low from 10 us up to the 1 ms sleep length.
// RULE_03: auto-recovering faults resume operation only after rail soft-starts finish.
// RULE_04: latched-block faults keep drivers blocked until enable pulse or clear write.
// RULE_05: full-recovery faults also release the fault output on that same event.
// RULE_06: overcurrent auto-retry keeps drivers blocked until the retry delay expires; code also unblocks on an earlier clear event.
// RULE_07: retry delay expiry releases the fault output and clears the status bit.
// RULE_08: report-only holds fault output low until clear event and fault gone.
// RULE_09: thermal warning status clears itself once rails are up and no other fault.
// RULE_10: thermal warning alone never blocks drivers or disturbs supplies.
// RULE_11: fault output is open-drain, active low, pulled low on any fault; code skips warnings under CFG_OTW_SILENT and overcurrent under FRX_OC_NONE.
// RULE_12: fault output releases only when all faults gone and rails started; code also releases during a silenced warning or FRX_OC_NONE overcurrent.
// RULE_13: fault output latches only for the two overcurrent faults.
// RULE_14: enable toggle or clear bit write releases fault output if fault gone.
// RULE_15: fault output carries a deglitch of about 1 us.
// RULE_16: host stops on fault output low and resumes once it is released.
package frx_pkg;
    localparam int CLK_MHZ = 250;
    localparam int SLEEP_US = 1000;
    localparam int SLEEP_CYC = SLEEP_US * CLK_MHZ;
    localparam int PULSE_MIN_US = 10;
    localparam int PULSE_MIN_CYC = PULSE_MIN_US * CLK_MHZ;
    localparam int DEGLITCH_US = 1;
    localparam int DEGLITCH_CYC = DEGLITCH_US * CLK_MHZ;
    localparam int RETRY_US = 1000;
    localparam int RETRY_CYC = RETRY_US * CLK_MHZ;
    localparam int CNT_W = 20;
    // register byte addresses
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_CONFIG = 4'h8;
    // control register fields
    localparam int CTRL_CLEAR_FAULT_BIT = 0;
    // config register fields
    localparam int CFG_OC_MODE_LO = 0;
    localparam int CFG_OTW_SILENT = 2;
    localparam logic [31:0] CFG_RESET = 32'h0000_0000;
    // status bit positions
    localparam int ST_DS_OC = 0;
    localparam int ST_SENSE_OC = 1;
    localparam int ST_OTW = 2;
    localparam int ST_BLOCK = 3;
    localparam int ST_OTHER = 4;
    localparam int ST_FAULT_PIN = 5;
    localparam int ST_SLEEP = 6;
    localparam int ST_RETRY = 7;
    // overcurrent handling option
    typedef enum logic [1:0] {
        FRX_OC_LATCH = 2'h0,
        FRX_OC_RETRY = 2'h1,
        FRX_OC_REPORT = 2'h2,
        FRX_OC_NONE = 2'h3
    } frx_oc_mode_t;
    // bus slave states
    typedef enum logic [1:0] {
        FRX_BUS_IDLE = 2'h1,
        FRX_BUS_ACK = 2'h2
    } frx_bus_t;
endpackage

/* logic/frx_timer_if.sv */
// interface between the top logic and the timer module
`timescale 1ns/1ns
`default_nettype none
interface frx_timer_if;
    logic run;
    logic [19:0] limit;
    logic done;
    modport owner (output run, output limit, input done);
    modport timer (input run, input limit, output done);
endinterface
`default_nettype wire

/* logic/frx_timer.sv */
// reusable up-counter that flags when a running level outlasts its limit
`timescale 1ns/1ns
`default_nettype none
module frx_timer
    import frx_pkg::*;
(
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    // control
    frx_timer_if.timer tif
);
    logic [CNT_W-1:0] count;

    // counts while run is high, restarts the moment run drops
    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            count <= '0;
            tif.done <= 1'b0;
        end
        else if (!tif.run)
        begin
            count <= '0;
            tif.done <= 1'b0;
        end
        else
        begin
            if (count != tif.limit)
                count <= count + 20'h00001;
            tif.done <= (count == tif.limit);
        end
    end
endmodule // frx_timer
`default_nettype wire

/* logic/frx_fault_recovery.sv */
// fault recovery and fault indicator logic with avalon register slave
//
// The register addresses and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module frx_fault_recovery
    import frx_pkg::*;
(
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    // pins and fault sources (asynchronous)
    input wire logic enable_pin_in,
    input wire logic drain_source_overcurrent_in,
    input wire logic sense_overcurrent_in,
    input wire logic overtemp_warning_in,
    input wire logic other_fault_in,
    input wire logic core_supply_undervoltage_in,
    input wire logic rails_ready_in,
    // avalon-mm slave
    input wire logic [3:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    // driver and power control
    output logic drivers_blocked_out,
    output logic sleep_out,
    output logic soft_start_req_out,
    // open-drain fault line, enable high pulls low
    output logic fault_indicator_low_out,
    output logic fault_indicator_low_oe_out
);
    // two-flop synchronisers for all asynchronous inputs
    localparam int NS = 7;
    // enable idles high; resetting its stages high keeps the edge
    // detector and the sleep timer quiet while reset lets go
    localparam logic [NS-1:0] SYNC_IDLE = 7'h01;
    logic [NS-1:0] sync_a;
    logic [NS-1:0] sync_b;
    logic [NS-1:0] raw_in;
    assign raw_in = {rails_ready_in, core_supply_undervoltage_in,
        other_fault_in, overtemp_warning_in, sense_overcurrent_in,
        drain_source_overcurrent_in, enable_pin_in};

    genvar gi;
    generate
        for (gi = 0; gi < NS; gi++)
        begin : g_sync
            always_ff @(posedge core_clk_in or negedge rst_n_in)
            begin
                if (!rst_n_in)
                begin
                    sync_a[gi] <= SYNC_IDLE[gi];
                    sync_b[gi] <= SYNC_IDLE[gi];
                end
                else
                begin
                    sync_a[gi] <= raw_in[gi];
                    sync_b[gi] <= sync_a[gi];
                end
            end
        end
    endgenerate

    logic en_s, ds_oc, sn_oc, overtemp_warning_flag, oth, uv, rails_ok;
    assign {rails_ok, uv, oth, overtemp_warning_flag, sn_oc, ds_oc, en_s} = sync_b;

    // software registers
    logic [31:0] cfg;
    logic clr_pulse;
    frx_oc_mode_t oc_mode;
    logic otw_silent;
    assign oc_mode = frx_oc_mode_t'(cfg[CFG_OC_MODE_LO +: 2]);
    assign otw_silent = cfg[CFG_OTW_SILENT];

    // enable pin: low-level timers for sleep and pulse width
    frx_timer_if sleep_tif ();
    frx_timer_if pulse_tif ();
    assign sleep_tif.run = !en_s;
    assign sleep_tif.limit = CNT_W'(SLEEP_CYC - 1);
    assign pulse_tif.run = !en_s && !pulse_tif.done;
    assign pulse_tif.limit = CNT_W'(PULSE_MIN_CYC - 1);

    frx_timer u_sleep_timer (
        .core_clk_in(core_clk_in),
        .rst_n_in(rst_n_in),
        .tif(sleep_tif)
    );

    // pulse timer done lasts one cycle; pulse_long keeps it until the pin rises
    logic pulse_long;
    frx_timer u_pulse_timer (
        .core_clk_in(core_clk_in),
        .rst_n_in(rst_n_in),
        .tif(pulse_tif)
    );

    logic en_prev;
    logic sleeping;
    // latches qualified width; a pulse past sleep length is a wake, not a clear
    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            pulse_long <= 1'b0;
        else if (en_s)
            pulse_long <= 1'b0;
        else if (pulse_tif.done)
            pulse_long <= 1'b1;
    end

    // previous synced enable for rising edge detection
    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            en_prev <= 1'b1;
        else
            en_prev <= en_s;
    end

    // enable rising edge after a qualified low pulse
    logic en_clear;
    assign en_clear = en_s && !en_prev && pulse_long && !sleeping; // RULE_02

    // sleep entry and wake; undervoltage still handled while asleep
    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            sleeping <= 1'b0;
        else if (sleep_tif.done)
            sleeping <= 1'b1; // RULE_01
        else if (en_s)
            sleeping <= 1'b0;
    end

    logic clear_evt;
    assign clear_evt = en_clear || clr_pulse; // RULE_14

    // latched status and blocking state
    logic ds_st, sn_st, otw_st, oth_st, block, oc_hold, retry_run;
    logic oc_now;
    assign oc_now = ds_oc || sn_oc;
    logic retry_done;
    frx_timer_if retry_tif ();
    assign retry_tif.run = retry_run;
    assign retry_tif.limit = CNT_W'(RETRY_CYC - 1);
    frx_timer u_retry_timer (
        .core_clk_in(core_clk_in),
        .rst_n_in(rst_n_in),
        .tif(retry_tif)
    );
    assign retry_done = retry_tif.done;

    // overcurrent status bits: set wins over any clear
    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            ds_st <= 1'b0;
            sn_st <= 1'b0;
        end
        else
        begin
            if (ds_oc)
                ds_st <= 1'b1;
            else if (clear_evt || retry_done)
                ds_st <= 1'b0; // RULE_07
            if (sn_oc)
                sn_st <= 1'b1;
            else if (clear_evt || retry_done)
                sn_st <= 1'b0; // RULE_04
        end
    end

    // other faults: auto-recovering rails, status cleared by clear event
    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            oth_st <= 1'b0;
        else if (oth || uv)
            oth_st <= 1'b1;
        else if (clear_evt)
            oth_st <= 1'b0; // RULE_04
    end

    // thermal warning clears itself once rails up and nothing else active
    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            otw_st <= 1'b0;
        else if (overtemp_warning_flag)
            otw_st <= 1'b1;
        else if (rails_ok && !oc_now && !oth && !uv)
            otw_st <= 1'b0; // RULE_09
    end

    // driver blocking: warning alone never blocks
    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            block <= 1'b0;
            retry_run <= 1'b0;
        end
        else
        begin
            if (oc_now && (oc_mode == FRX_OC_LATCH || oc_mode == FRX_OC_RETRY))
                block <= 1'b1; // RULE_06
            else if (oth || uv)
                block <= 1'b1;
            else if (oc_mode == FRX_OC_RETRY && retry_done)
                block <= 1'b0; // RULE_06
            else if (clear_evt && rails_ok)
                block <= 1'b0; // RULE_04
            // retry delay restarts while the fault persists; a lone
            // thermal warning never holds it back
            retry_run <= (oc_mode == FRX_OC_RETRY) && block && !oc_now
                && !retry_done && !oth && !uv; // RULE_10
        end
    end

    // latched fault-line hold for the two overcurrent faults
    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            oc_hold <= 1'b0;
        else if (oc_now && oc_mode != FRX_OC_NONE)
            oc_hold <= 1'b1; // RULE_13
        else if (retry_done)
            oc_hold <= 1'b0; // RULE_07
        else if (clear_evt)
            oc_hold <= 1'b0; // RULE_05 RULE_08
    end

    // raw request to pull the fault line low
    logic pull_req;
    assign pull_req = oc_hold || oth || uv || !rails_ok
        || (otw_st && !otw_silent); // RULE_11 RULE_12

    // deglitch: line follows request only after it stands steady ~1 us
    logic [CNT_W-1:0] dg_cnt;
    logic line_low;
    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            dg_cnt <= '0;
            line_low <= 1'b0;
        end
        else if (pull_req == line_low)
            dg_cnt <= '0;
        else if (dg_cnt == CNT_W'(DEGLITCH_CYC - 1))
        begin
            dg_cnt <= '0;
            line_low <= pull_req; // RULE_15
        end
        else
            dg_cnt <= dg_cnt + 20'h00001;
    end

    // pin and control outputs, all from flops
    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            fault_indicator_low_out <= 1'b0;
            fault_indicator_low_oe_out <= 1'b0;
            drivers_blocked_out <= 1'b0;
            sleep_out <= 1'b0;
            soft_start_req_out <= 1'b0;
        end
        else
        begin
            fault_indicator_low_out <= 1'b0;
            fault_indicator_low_oe_out <= line_low; // RULE_11
            drivers_blocked_out <= block || sleeping || !rails_ok; // RULE_03
            sleep_out <= sleeping;
            soft_start_req_out <= !rails_ok && !sleeping; // RULE_03
        end
    end

    // avalon slave: one wait cycle, answer on the second
    frx_bus_t bus;
    logic [31:0] status_word;
    always_comb
    begin
        status_word = 32'h0000_0000;
        status_word[ST_DS_OC] = ds_st;
        status_word[ST_SENSE_OC] = sn_st;
        status_word[ST_OTW] = otw_st;
        status_word[ST_BLOCK] = block;
        status_word[ST_OTHER] = oth_st;
        status_word[ST_FAULT_PIN] = line_low;
        status_word[ST_SLEEP] = sleeping;
        status_word[ST_RETRY] = retry_run;
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            bus <= FRX_BUS_IDLE;
            avs_waitrequest_out <= 1'b1;
            avs_readdata_out <= 32'h0000_0000;
            cfg <= CFG_RESET;
            clr_pulse <= 1'b0;
        end
        else
        begin
            clr_pulse <= 1'b0;
            unique case (bus)
                FRX_BUS_IDLE:
                begin
                    if (avs_read_in || avs_write_in)
                    begin
                        bus <= FRX_BUS_ACK;
                        avs_waitrequest_out <= 1'b0;
                        unique case (avs_address_in)
                            ADDR_STATUS: avs_readdata_out <= status_word;
                            ADDR_CONFIG: avs_readdata_out <= cfg;
                            default: avs_readdata_out <= 32'h0000_0000;
                        endcase
                    end
                end
                FRX_BUS_ACK:
                begin
                    bus <= FRX_BUS_IDLE;
                    avs_waitrequest_out <= 1'b1;
                    // writes land here, at the edge the master sees
                    // waitrequest low; the request still stands now
                    if (avs_write_in && avs_address_in == ADDR_CTRL)
                        clr_pulse <= avs_writedata_in[CTRL_CLEAR_FAULT_BIT]; // RULE_14
                    if (avs_write_in && avs_address_in == ADDR_CONFIG)
                        cfg <= {29'h0, avs_writedata_in[2:0]};
                end
                default:
                begin
                    bus <= FRX_BUS_IDLE;
                    avs_waitrequest_out <= 1'b1;
                end
            endcase
        end
    end
endmodule // frx_fault_recovery
`default_nettype wire

/* verif/frx_host_model.sv */
// host controller model: enable pulser and pulled-up fault line
`timescale 1ns/1ns
`default_nettype none
module frx_host_model
(
    // clock
    input wire logic core_clk_in,
    // open-drain fault line from the device
    input wire logic fault_indicator_low_in,
    input wire logic fault_indicator_low_oe_in,
    // enable pin and resolved line
    output var logic enable_pin_out,
    output logic fault_line_out,
    output logic halted_out
);
    initial enable_pin_out = 1'b1;
    // pull-up wins unless the device sinks the line
    assign fault_line_out = fault_indicator_low_oe_in ?
        fault_indicator_low_in : 1'b1;
    // host leaves normal work while the line is low
    assign halted_out = !fault_line_out;
    // 20 us low: inside the recovery window, far below sleep length
    task automatic en_pulse();
        enable_pin_out <= 1'b0;
        repeat (5000) @(posedge core_clk_in);
        enable_pin_out <= 1'b1;
    endtask
endmodule // frx_host_model
`default_nettype wire

/* verif/frx_fault_recovery_monitor.sv */
// concurrent checks on the fault recovery block ports
`timescale 1ns/1ns
`default_nettype none
module frx_fault_recovery_monitor
    import frx_pkg::*;
(
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    // pins and fault sources
    input wire logic enable_pin_in,
    input wire logic drain_source_overcurrent_in,
    input wire logic sense_overcurrent_in,
    input wire logic overtemp_warning_in,
    input wire logic other_fault_in,
    input wire logic core_supply_undervoltage_in,
    input wire logic rails_ready_in,
    // register bus
    input wire logic [3:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [31:0] avs_readdata_out,
    input wire logic avs_waitrequest_out,
    // driver, power and fault line
    input wire logic drivers_blocked_out,
    input wire logic sleep_out,
    input wire logic soft_start_req_out,
    input wire logic fault_indicator_low_out,
    input wire logic fault_indicator_low_oe_out
);
    logic cause;
    logic [9:0] run_cnt;
    logic [9:0] calm_cnt;
    logic [9:0] dark_cnt;
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);
    // any fault source or rails not up
    assign cause = drain_source_overcurrent_in | sense_overcurrent_in |
        overtemp_warning_in | other_fault_in |
        core_supply_undervoltage_in | !rails_ready_in;
    // cycles a cause has stood without a break
    always_ff @(posedge core_clk_in or negedge rst_n_in)
        if (!rst_n_in)
            run_cnt <= 10'h000;
        else if (!cause)
            run_cnt <= 10'h000;
        else if (run_cnt != 10'h3FF)
            run_cnt <= run_cnt + 10'h001;
    // cycles with no cause at all
    always_ff @(posedge core_clk_in or negedge rst_n_in)
        if (!rst_n_in)
            calm_cnt <= 10'h000;
        else if (cause)
            calm_cnt <= 10'h000;
        else if (calm_cnt != 10'h3FF)
            calm_cnt <= calm_cnt + 10'h001;
    // cycles the rails have been down
    always_ff @(posedge core_clk_in or negedge rst_n_in)
        if (!rst_n_in)
            dark_cnt <= 10'h000;
        else if (rails_ready_in)
            dark_cnt <= 10'h000;
        else if (dark_cnt != 10'h3FF)
            dark_cnt <= dark_cnt + 10'h001;
    sequence s_calm;
        (!drain_source_overcurrent_in && !sense_overcurrent_in &&
         !other_fault_in && !core_supply_undervoltage_in &&
         rails_ready_in && enable_pin_in) [*6];
    endsequence
    sequence s_clr;
        avs_write_in && !avs_waitrequest_out &&
        avs_address_in == ADDR_CTRL && avs_writedata_in[CTRL_CLEAR_FAULT_BIT];
    endsequence
    AST_OD_DATA: assert property (fault_indicator_low_oe_out |->
        !fault_indicator_low_out) else $error("fault line data not low");
    AST_BUS_ANSWER: assert property ((avs_read_in || avs_write_in) &&
        avs_waitrequest_out |=> !avs_waitrequest_out)
        else $error("bus answer late");
    AST_BUS_STANDS: assert property (!avs_waitrequest_out |=>
        avs_waitrequest_out) else $error("answer held too long");
    AST_RAILS_BLOCK: assert property (!rails_ready_in [*8] |->
        drivers_blocked_out || sleep_out)
        else $error("drivers free while rails down");
    AST_RAILS_FAULT: assert property (dark_cnt >= 10'h12C |->
        fault_indicator_low_oe_out || sleep_out)
        else $error("fault line free while rails down");
    AST_DEGLITCH_SET: assert property ($rose(fault_indicator_low_oe_out)
        |-> run_cnt >= 10'h0F0) else $error("line pulled too soon");
    AST_DEGLITCH_CLR: assert property ($fell(fault_indicator_low_oe_out)
        |-> calm_cnt >= 10'h0F0) else $error("line freed too soon");
    AST_OTW_NO_BLOCK: assert property (s_calm ##0 !drivers_blocked_out
        |=> !drivers_blocked_out) else $error("warning blocked");
    AST_CLEAR_UNBLOCK: assert property (s_calm ##0 s_clr |->
        ##[1:6] !drivers_blocked_out) else $error("clear ignored");
endmodule // frx_fault_recovery_monitor
bind frx_fault_recovery frx_fault_recovery_monitor
    frx_fault_recovery_monitor_inst (.*);
`default_nettype wire

/* verif/frx_fault_recovery_tb.sv */
// self-checking bench for the fault recovery block
`timescale 1ns/1ns
`default_nettype none
module frx_fault_recovery_tb;
    import frx_pkg::*;
    logic core_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic drain_source_overcurrent_in = 1'b0;
    logic sense_overcurrent_in = 1'b0;
    logic overtemp_warning_in = 1'b0;
    logic other_fault_in = 1'b0;
    logic core_supply_undervoltage_in = 1'b0;
    logic rails_ready_in = 1'b0;
    logic [3:0] avs_address_in = 4'h0;
    logic avs_read_in = 1'b0;
    logic avs_write_in = 1'b0;
    logic [31:0] avs_writedata_in = 32'h0;
    logic [31:0] avs_readdata_out;
    logic [31:0] q;
    logic avs_waitrequest_out, drivers_blocked_out, sleep_out;
    logic soft_start_req_out, fault_indicator_low_out;
    logic fault_indicator_low_oe_out, enable_pin_in, fault_line;
    int err_total = 0;
    int n_checks = 0;
    // device and host model
    frx_fault_recovery frx_fault_recovery_inst (.*);
    frx_host_model frx_host_model_inst (
        .core_clk_in(core_clk_in),
        .fault_indicator_low_in(fault_indicator_low_out),
        .fault_indicator_low_oe_in(fault_indicator_low_oe_out),
        .enable_pin_out(enable_pin_in),
        .fault_line_out(fault_line),
        .halted_out()
    );
    always #2 core_clk_in = ~core_clk_in;
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk_in);
    endtask
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_checks++;
        if (g !== e)
        begin
            err_total++;
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
        end
    endtask
    // one bus access; waits for waitrequest low, bounded
    task automatic bus(input logic w, input logic [3:0] a,
        input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        avs_address_in <= a;
        avs_writedata_in <= d;
        avs_write_in <= w;
        avs_read_in <= !w;
        do @(posedge core_clk_in);
        while (avs_waitrequest_out !== 1'b0 && ++n < 50);
        r = avs_readdata_out;
        chk("waitrequest", 1'b0, avs_waitrequest_out);
        avs_write_in <= 1'b0;
        avs_read_in <= 1'b0;
        @(posedge core_clk_in);
    endtask
    task automatic clr();
        bus(1'b1, ADDR_CTRL, 32'h1 << CTRL_CLEAR_FAULT_BIT, q);
    endtask
    task automatic st(input logic [7:0] e);
        bus(1'b0, ADDR_STATUS, 32'h0, q);
        chk("status", e, q[7:0]);
    endtask
    task automatic ln(input logic bl, input logic fl);
        chk("blocked", bl, drivers_blocked_out);
        chk("fault line", fl, fault_line);
    endtask
    task automatic t_power_up();
        cyc(300);
        chk("soft start", 1'b1, soft_start_req_out);
        ln(1'b1, 1'b0);
        bus(1'b0, ADDR_CONFIG, 32'h0, q);
        chk("config", CFG_RESET, q);
        bus(1'b0, 4'hC, 32'h0, q);
        chk("unmapped", 32'h0, q);
        rails_ready_in <= 1'b1;
        cyc(300);
        chk("soft start", 1'b0, soft_start_req_out);
        ln(1'b0, 1'b1);
        $display("power up test done");
    endtask
    // overcurrent latch, cleared by write (k=0) or enable pulse (k=1)
    task automatic t_latch(input int k);
        drain_source_overcurrent_in <= (k == 0);
        sense_overcurrent_in <= (k == 1);
        cyc(300);
        ln(1'b1, 1'b0);
        st(8'h28 | (8'h1 << k));
        drain_source_overcurrent_in <= 1'b0;
        sense_overcurrent_in <= 1'b0;
        cyc(400);
        ln(1'b1, 1'b0);
        if (k == 0)
            clr();
        else
            frx_host_model_inst.en_pulse();
        cyc(10);
        chk("blocked", 1'b0, drivers_blocked_out);
        chk("sleep", 1'b0, sleep_out);
        cyc(300);
        ln(1'b0, 1'b1);
        st(8'h00);
        bus(1'b0, ADDR_CTRL, 32'h0, q);
        chk("control", 32'h0, q);
        $display("latch test %0d done", k);
    endtask
    task automatic t_otw();
        overtemp_warning_in <= 1'b1;
        cyc(300);
        ln(1'b0, 1'b0);
        st(8'h24);
        overtemp_warning_in <= 1'b0;
        cyc(300);
        ln(1'b0, 1'b1);
        st(8'h00);
        bus(1'b1, ADDR_CONFIG, 32'h1 << CFG_OTW_SILENT, q);
        overtemp_warning_in <= 1'b1;
        cyc(300);
        ln(1'b0, 1'b1);
        st(8'h04);
        overtemp_warning_in <= 1'b0;
        bus(1'b1, ADDR_CONFIG, 32'h0, q);
        cyc(20);
        st(8'h00);
        $display("warning test done");
    endtask
    // other fault (k=0) or undervoltage (k=1) frees the line by itself
    task automatic t_other(input int k);
        other_fault_in <= (k == 0);
        core_supply_undervoltage_in <= (k == 1);
        cyc(300);
        ln(1'b1, 1'b0);
        st(8'h38);
        other_fault_in <= 1'b0;
        core_supply_undervoltage_in <= 1'b0;
        cyc(300);
        chk("fault line", 1'b1, fault_line);
        clr();
        cyc(10);
        ln(1'b0, 1'b1);
        $display("other test %0d done", k);
    endtask
    task automatic t_modes();
        bus(1'b1, ADDR_CONFIG, {30'h0, FRX_OC_REPORT}, q);
        drain_source_overcurrent_in <= 1'b1;
        cyc(300);
        ln(1'b0, 1'b0);
        st(8'h21);
        clr();
        cyc(300);
        ln(1'b0, 1'b0);
        drain_source_overcurrent_in <= 1'b0;
        cyc(300);
        ln(1'b0, 1'b0);
        clr();
        cyc(300);
        ln(1'b0, 1'b1);
        bus(1'b1, ADDR_CONFIG, {30'h0, FRX_OC_NONE}, q);
        drain_source_overcurrent_in <= 1'b1;
        cyc(300);
        ln(1'b0, 1'b1);
        drain_source_overcurrent_in <= 1'b0;
        cyc(5);
        clr();
        bus(1'b1, ADDR_CONFIG, {30'h0, FRX_OC_RETRY}, q);
        sense_overcurrent_in <= 1'b1;
        cyc(300);
        st(8'h2A);
        sense_overcurrent_in <= 1'b0;
        cyc(600);
        ln(1'b1, 1'b0);
        st(8'hAA);
        // reset in mid retry: retry delay is too long to sit out
        rst_n_in <= 1'b0;
        cyc(2);
        rst_n_in <= 1'b1;
        cyc(300);
        ln(1'b0, 1'b1);
        bus(1'b0, ADDR_CONFIG, 32'h0, q);
        chk("config", CFG_RESET, q);
        $display("mode test done");
    endtask
    task automatic finish_test();
        $display("checks %0d, mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        cyc(16);
        rst_n_in <= 1'b1;
        t_power_up();
        t_latch(0);
        t_latch(1);
        t_otw();
        t_other(0);
        t_other(1);
        t_modes();
        finish_test();
    end
    // watchdog well past the expected run length
    initial
    begin
        cyc(40000);
        err_total++;
        finish_test();
    end
endmodule // frx_fault_recovery_tb
`default_nettype wire
